// ### src/dsx_defs.svh
// Constants for the decrement-skip execution block
`ifndef DSX_DEFS_SVH
`define DSX_DEFS_SVH
`define DSX_OPC_HI       6'h0B
`define DSX_OPC_NZ       6'h13
`define DSX_OPC_MSB      15
`define DSX_OPC_LSB      10
`define DSX_D_BIT        9
`define DSX_A_BIT        8
`define DSX_F_MSB        7
`define DSX_F_LSB        0
`define DSX_ILO_MAX      8'h5F
`define DSX_ACC_SPLIT    8'h60
`define DSX_ACC_BANK_HI  4'hF
`define DSX_ONE          8'h01
`define DSX_ZERO         8'h00
`define DSX_Q1           2'h0
`define DSX_Q3           2'h2
`define DSX_Q4           2'h3
`endif

// ### src/dsx_pkg.sv
// Types for the decrement-skip execution block
package dsx_pkg;
    typedef enum logic [1:0] {
        DSX_EXEC  = 2'h0,
        DSX_SKIP1 = 2'h1,
        DSX_SKIP2 = 2'h3
    } dsx_state_t;
    typedef enum logic [1:0] {
        DSX_MODE_ACCESS = 2'h0,
        DSX_MODE_BANKED = 2'h1,
        DSX_MODE_INDEX  = 2'h2
    } dsx_mode_t;
endpackage : dsx_pkg

// ### src/dsx_addr_if.sv
// Address request and answer between the core and the address former
interface dsx_addr_if;
    logic [7:0]         file_addr;
    logic               access_bit;
    logic [3:0]         bank_pointer;
    logic               ext_enable;
    logic [7:0]         index_base;
    logic [11:0]        full_addr;
    dsx_pkg::dsx_mode_t mode;
    modport core (output file_addr, access_bit, bank_pointer, ext_enable, index_base,
                  input full_addr, mode);
    modport former (input file_addr, access_bit, bank_pointer, ext_enable, index_base,
                    output full_addr, mode);
endinterface : dsx_addr_if

// ### src/dsx_addr_form.sv
// Address former: access bank, banked or indexed literal offset
`include "dsx_defs.svh"
module dsx_addr_form (
    dsx_addr_if.former port_if
);
    logic [11:0] index_sum;
    assign index_sum = {4'h0, port_if.index_base} + {4'h0, port_if.file_addr};
    always_comb begin
        if (port_if.access_bit) begin
            port_if.mode      = dsx_pkg::DSX_MODE_BANKED;
            port_if.full_addr = {port_if.bank_pointer, port_if.file_addr};
        end else if (port_if.ext_enable && port_if.file_addr <= `DSX_ILO_MAX) begin
            port_if.mode      = dsx_pkg::DSX_MODE_INDEX;
            port_if.full_addr = index_sum;
        end else if (port_if.file_addr < `DSX_ACC_SPLIT) begin
            port_if.mode      = dsx_pkg::DSX_MODE_ACCESS;
            port_if.full_addr = {4'h0, port_if.file_addr};
        end else begin
            // Upper access part (60h and above) maps onto the special register bank
            port_if.mode      = dsx_pkg::DSX_MODE_ACCESS;
            port_if.full_addr = {`DSX_ACC_BANK_HI, port_if.file_addr};
        end
    end
endmodule : dsx_addr_form

// ### src/dsx_core.sv
// Execution of the decrement-and-skip instructions over four phases
// Behaviour
// - Decrement-skip-on-zero takes one cycle, two when it skips, three when skipping a two-word instruction.
// - Every phase of a skipped cycle is idle, with a second idle cycle for a two-word discarded instruction.
// - The decremented value goes to the accumulator when the destination bit is 0, else back to the file register.
// - Decrement-skip-on-nonzero discards the prefetched instruction when the result is not zero.
// - Access bit 0 selects the access bank; 1 lets the bank pointer choose the general register bank.
// - Access bit 0 with the extended set enabled uses indexed literal offset for file addresses up to 95.
// - Decrement-skip-on-nonzero takes one cycle, two when it skips, three when skipping a two-word instruction.
// - Decrement-skip-on-zero discards the prefetched instruction when the result is zero.
`include "dsx_defs.svh"
module dsx_core (
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic [1:0]  phase_in,
    input  wire logic [15:0] instr_in,
    input  wire logic        instr_valid_in,
    input  wire logic        next_two_word_in,
    input  wire logic [3:0]  bank_pointer_in,
    input  wire logic        ext_enable_in,
    input  wire logic [7:0]  index_base_in,
    input  wire logic [7:0]  file_data_in,
    output logic [11:0]      read_addr_out,
    output logic             read_en_out,
    output logic [11:0]      write_addr_out,
    output logic [7:0]       write_data_out,
    output logic             file_we_out,
    output logic             accum_we_out,
    output logic             idle_instruction_out,
    output logic             skip_out,
    output logic             busy_out,
    output logic [1:0]       addr_mode_out
);
    dsx_addr_if addr_bus ();
    dsx_pkg::dsx_state_t state;
    dsx_pkg::dsx_state_t next_state;
    logic                is_zero_op;
    logic                is_nz_op;
    logic                is_op;
    logic                dest_file;
    logic [7:0]          result;
    logic                result_zero;
    logic                take_skip;
    logic                held_op;
    logic                held_dest;
    logic [11:0]         held_addr;
    logic [7:0]          held_result;
    logic                held_zero;

    assign addr_bus.file_addr    = instr_in[`DSX_F_MSB:`DSX_F_LSB];
    assign addr_bus.access_bit   = instr_in[`DSX_A_BIT];
    assign addr_bus.bank_pointer = bank_pointer_in;
    assign addr_bus.ext_enable   = ext_enable_in;
    assign addr_bus.index_base   = index_base_in;

    dsx_addr_form u_addr (
        .port_if (addr_bus)
    );

    assign is_zero_op  = instr_in[`DSX_OPC_MSB:`DSX_OPC_LSB] == `DSX_OPC_HI;
    assign is_nz_op    = instr_in[`DSX_OPC_MSB:`DSX_OPC_LSB] == `DSX_OPC_NZ;
    assign is_op       = instr_valid_in && (is_zero_op || is_nz_op) && state == dsx_pkg::DSX_EXEC;
    assign dest_file   = instr_in[`DSX_D_BIT];
    assign result      = file_data_in - `DSX_ONE;
    // Zero test on the held result: file data is only valid during Q2 and Q3
    assign result_zero = held_result == `DSX_ZERO;
    // Skip sense is opposite for the two opcodes
    assign take_skip   = held_op && ((held_zero && result_zero)
                                   || (!held_zero && !result_zero));

    // Decode latches the operand address in Q1; the file read is presented in Q2
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_op <= 1'b0;
        end else if (phase_in == `DSX_Q1) begin
            held_op <= is_op;
        end
    end

    // Opcode sense held so a late change of the decode word cannot flip the skip
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_zero <= 1'b0;
        end else if (phase_in == `DSX_Q1) begin
            held_zero <= is_zero_op;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_dest <= 1'b0;
        end else if (phase_in == `DSX_Q1) begin
            held_dest <= dest_file;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_addr <= 12'h000;
        end else if (phase_in == `DSX_Q1) begin
            held_addr <= addr_bus.full_addr;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_addr_out <= 12'h000;
        end else begin
            read_addr_out <= addr_bus.full_addr;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_en_out <= 1'b0;
        end else begin
            read_en_out <= is_op && phase_in == `DSX_Q1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_mode_out <= 2'h0;
        end else begin
            addr_mode_out <= addr_bus.mode;
        end
    end

    // Result captured at end of Q3 for the Q4 write
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            held_result <= 8'h00;
        end else if (held_op && phase_in == `DSX_Q3) begin
            held_result <= result;
        end
    end

    // Address and data follow every clock; only the strobes qualify them
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_addr_out <= 12'h000;
        end else begin
            write_addr_out <= held_addr;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_data_out <= 8'h00;
        end else begin
            write_data_out <= held_result;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            file_we_out <= 1'b0;
        end else begin
            file_we_out <= held_op && phase_in == `DSX_Q4 && held_dest;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            accum_we_out <= 1'b0;
        end else begin
            accum_we_out <= held_op && phase_in == `DSX_Q4 && !held_dest;
        end
    end

    // Skip decision is made at Q4; the idle cycles follow from the next Q1
    always_comb begin
        next_state = state;
        if (phase_in == `DSX_Q4) begin
            unique case (state)
                dsx_pkg::DSX_EXEC: begin
                    if (take_skip) begin
                        next_state = dsx_pkg::DSX_SKIP1;
                    end
                end
                dsx_pkg::DSX_SKIP1: begin
                    next_state = next_two_word_in ? dsx_pkg::DSX_SKIP2 : dsx_pkg::DSX_EXEC;
                end
                dsx_pkg::DSX_SKIP2: begin
                    next_state = dsx_pkg::DSX_EXEC;
                end
                default: begin
                    next_state = dsx_pkg::DSX_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= dsx_pkg::DSX_EXEC;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            idle_instruction_out <= 1'b0;
        end else begin
            idle_instruction_out <= next_state != dsx_pkg::DSX_EXEC;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            skip_out <= 1'b0;
        end else begin
            skip_out <= phase_in == `DSX_Q4 && state == dsx_pkg::DSX_EXEC && take_skip;
        end
    end

    // Busy spans Q2 and Q3 of the op cycle and Q1 of the cycle after it, as well as the idle cycles behind it
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_out <= 1'b0;
        end else begin
            busy_out <= next_state != dsx_pkg::DSX_EXEC || (held_op && phase_in != `DSX_Q4);
        end
    end
endmodule : dsx_core

// ### verification/dsx_core_chk.sv
// Assertion checker for the decrement-skip core
module dsx_core_chk (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic [1:0]  phase_in,
    input wire logic [15:0] instr_in,
    input wire logic        instr_valid_in,
    input wire logic        next_two_word_in,
    input wire logic [3:0]  bank_pointer_in,
    input wire logic        ext_enable_in,
    input wire logic [7:0]  index_base_in,
    input wire logic [7:0]  file_data_in,
    input wire logic [11:0] read_addr_out,
    input wire logic        read_en_out,
    input wire logic [7:0]  write_data_out,
    input wire logic        file_we_out,
    input wire logic        accum_we_out,
    input wire logic        idle_instruction_out,
    input wire logic        skip_out,
    input wire logic        busy_out,
    input wire logic [1:0]  addr_mode_out
);
    wire opz  = instr_in[15:10] == 6'h0B;
    wire opn  = instr_in[15:10] == 6'h13;
    // Skip cycles refuse a new instruction, so they are kept out
    wire take = phase_in == 2'h0 && instr_valid_in && !skip_out && !idle_instruction_out && (opz || opn);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_bank;
        take && instr_in[8] |=> addr_mode_out == 2'h1
            && read_addr_out == {$past(bank_pointer_in), $past(instr_in[7:0])};
    endproperty
    a_bank: assert property (p_bank) else $error("banked address wrong");
    property p_idx;
        take && !instr_in[8] && ext_enable_in && instr_in[7:0] <= 8'h5F |=> addr_mode_out == 2'h2
            && read_addr_out == {4'h0, $past(index_base_in)} + {4'h0, $past(instr_in[7:0])};
    endproperty
    a_idx: assert property (p_idx) else $error("indexed address wrong");
    property p_acc;
        take && !instr_in[8] && !(ext_enable_in && instr_in[7:0] <= 8'h5F) |=> addr_mode_out == 2'h0
            && read_addr_out == {($past(instr_in[7:0]) < 8'h60) ? 4'h0 : 4'hF, $past(instr_in[7:0])};
    endproperty
    a_acc: assert property (p_acc) else $error("access bank address wrong");
    property p_wdata; read_en_out |-> ##3 write_data_out == $past(file_data_in, 2) - 8'h01; endproperty
    a_wdata: assert property (p_wdata) else $error("result wrong");
    property p_dest;
        take |-> ##4 file_we_out == $past(instr_in[9], 4) && accum_we_out == !$past(instr_in[9], 4);
    endproperty
    a_dest: assert property (p_dest) else $error("destination wrong");
    property p_skz; take && opz |-> ##4 skip_out == (write_data_out == 8'h00); endproperty
    a_skz: assert property (p_skz) else $error("zero skip wrong");
    property p_sknz; take && opn |-> ##4 skip_out == (write_data_out != 8'h00); endproperty
    a_sknz: assert property (p_sknz) else $error("nonzero skip wrong");
    property p_idle;
        skip_out |-> idle_instruction_out[*4] ##1 idle_instruction_out == $past(next_two_word_in);
    endproperty
    a_idle: assert property (p_idle) else $error("idle cycles wrong");
    property p_quiet; idle_instruction_out && !skip_out |-> !file_we_out && !accum_we_out && !read_en_out; endproperty
    a_quiet: assert property (p_quiet) else $error("activity while idle");
    property p_busy; idle_instruction_out |-> busy_out; endproperty
    a_busy: assert property (p_busy) else $error("not busy while idle");
endmodule : dsx_core_chk

bind dsx_core dsx_core_chk chk (
    .clk_in               (clk_in),
    .rst_n_in             (rst_n_in),
    .phase_in             (phase_in),
    .instr_in             (instr_in),
    .instr_valid_in       (instr_valid_in),
    .next_two_word_in     (next_two_word_in),
    .bank_pointer_in      (bank_pointer_in),
    .ext_enable_in        (ext_enable_in),
    .index_base_in        (index_base_in),
    .file_data_in         (file_data_in),
    .read_addr_out        (read_addr_out),
    .read_en_out          (read_en_out),
    .write_data_out       (write_data_out),
    .file_we_out          (file_we_out),
    .accum_we_out         (accum_we_out),
    .idle_instruction_out (idle_instruction_out),
    .skip_out             (skip_out),
    .busy_out             (busy_out),
    .addr_mode_out        (addr_mode_out)
);

// ### verification/decrement_skip_execution_tb.sv
// Self-checking bench for the decrement-skip core
module decrement_skip_execution_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  phase_in = 2'h0, addr_mode_out;
    logic [15:0] instr_in = 16'h0000;
    logic [3:0]  bank_pointer_in = 4'h0;
    logic [7:0]  index_base_in = 8'h00, file_data_in = 8'h00, write_data_out;
    logic [11:0] read_addr_out, write_addr_out;
    logic        clk_in = 1'b0, rst_n_in = 1'b0, instr_valid_in = 1'b0, next_two_word_in = 1'b0, ext_enable_in = 1'b0;
    logic        read_en_out, file_we_out, accum_we_out, idle_instruction_out, skip_out, busy_out;
    logic [21:0] notes[$];
    int          fail_count = 0, total_checks = 0, pend = 0;
    dsx_core uut (
        .clk_in               (clk_in),
        .rst_n_in             (rst_n_in),
        .phase_in             (phase_in),
        .instr_in             (instr_in),
        .instr_valid_in       (instr_valid_in),
        .next_two_word_in     (next_two_word_in),
        .bank_pointer_in      (bank_pointer_in),
        .ext_enable_in        (ext_enable_in),
        .index_base_in        (index_base_in),
        .file_data_in         (file_data_in),
        .read_addr_out        (read_addr_out),
        .read_en_out          (read_en_out),
        .write_addr_out       (write_addr_out),
        .write_data_out       (write_data_out),
        .file_we_out          (file_we_out),
        .accum_we_out         (accum_we_out),
        .idle_instruction_out (idle_instruction_out),
        .skip_out             (skip_out),
        .busy_out             (busy_out),
        .addr_mode_out        (addr_mode_out)
    );
    always #20 clk_in = ~clk_in;
    always @(negedge clk_in) phase_in <= rst_n_in ? phase_in + 2'h1 : 2'h0;
    task automatic chk(input string n, input logic [21:0] e, input logic [21:0] s);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One instruction cycle; pend tracks cycles the core must refuse
    task automatic op(input logic [5:0] opc, input logic v, input logic [1:0] da, input logic [7:0] f,
                      input logic two, input logic [7:0] data);
        logic [3:0]  bp = 4'($urandom);
        logic        ex = 1'($urandom);
        logic [7:0]  ib = 8'($urandom);
        logic [7:0]  r;
        logic [11:0] ad;
        r = data - 8'h01;
        do @(negedge clk_in); while (phase_in !== 2'h3);
        {bank_pointer_in, ext_enable_in, index_base_in, file_data_in} <= {bp, ex, ib, data};
        {instr_in, instr_valid_in, next_two_word_in} <= {opc, da, f, v, two};
        if (pend == 1) pend = two ? 2 : 0;
        else if (pend == 2) pend = 0;
        else if (v && (opc == 6'h0B || opc == 6'h13)) begin
            ad = da[0] ? {bp, f}
                 : (ex && f <= 8'h5F) ? {4'h0, ib} + {4'h0, f} : {f < 8'h60 ? 4'h0 : 4'hF, f};
            pend = ((opc == 6'h0B) == (r == 8'h00)) ? 1 : 0;
            notes.push_back({pend[0], da[1], r, ad});
        end
    endtask : op
    always @(negedge clk_in) if (file_we_out === 1'b1 || accum_we_out === 1'b1) begin
        chk("result", notes.size() ? notes.pop_front() : 22'h3FFFFF,
            {skip_out, file_we_out, write_data_out, write_addr_out});
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    initial begin
        #100us;
        fail_count++;
        close_out();
    end
    initial begin
        void'($urandom(32'h2E32E798));
        repeat (5) @(negedge clk_in);
        rst_n_in <= 1'b1;
        // Boundaries: zero result, wrap, f at 5F and 60, two-word skip, refused slots
        op(6'h0B, 1'b1, 2'b11, 8'h5F, 1'b0, 8'h01);
        op(6'h13, 1'b1, 2'b00, 8'h60, 1'b1, 8'h05);
        op(6'h13, 1'b1, 2'b10, 8'h10, 1'b0, 8'h05);
        op(6'h13, 1'b1, 2'b00, 8'h5F, 1'b0, 8'h01);
        op(6'h0B, 1'b1, 2'b10, 8'h60, 1'b0, 8'h03);
        op(6'h13, 1'b1, 2'b01, 8'h20, 1'b0, 8'h00);
        op(6'h0B, 1'b1, 2'b00, 8'h00, 1'b0, 8'h01);
        op(6'h0A, 1'b1, 2'b10, 8'h30, 1'b0, 8'h01);
        op(6'h0B, 1'b0, 2'b10, 8'h30, 1'b0, 8'h01);
        $display("directed test done");
        // Random mix, data biased to 0 and 1 so both skip senses fire
        for (int i = 0; i < 80; i++)
            op(i % 3 == 2 ? 6'h0A : (i % 3 ? 6'h13 : 6'h0B), $urandom % 5 != 0,
               2'($urandom), 8'($urandom), 1'($urandom),
               $urandom % 3 == 0 ? 8'(i % 2) : 8'($urandom));
        // A held word would be taken again at every Q1, so the slot is emptied
        op(6'h00, 1'b0, 2'b00, 8'h00, 1'b0, 8'h00);
        repeat (16) @(negedge clk_in);
        chk("leftover", 22'h0, 22'(notes.size()));
        $display("random test done");
        close_out();
    end
endmodule : decrement_skip_execution_tb
